// ### pkg/pci_wide_cfg.svh
// Purpose: Constants for the 32-bit PCI target with a 64-bit local side
// Assumes: Memory commands only; slow device-select timing
// Notes:   Window bases are plain defaults, change per board
`ifndef PCI_WIDE_CFG_SVH
`define PCI_WIDE_CFG_SVH

`define PCI_AD_W        32
`define LOCAL_DATA_W    64
`define PCI_CMD_W       4
`define BAR_COUNT       2
`define BAR0_BASE       32'h1000_0000
`define BAR1_BASE       32'h2000_0000
`define BAR_SIZE_MASK   32'hfff0_0000
`define CMD_MEM_READ    4'h6
`define CMD_MEM_WRITE   4'h7
`define CMD_DIR_BIT     0
`define QWORD_SEL_BIT   2
`define HALF_LO_MSB     31
`define HALF_HI_LSB     32
`define AHEAD_LIMIT     2'h2
`define AHEAD_ONE       2'h1

`endif

// ### pkg/pci_wide_pkg.sv
// Purpose: Types for the 32-bit PCI target with a 64-bit local side
// Assumes: pci_wide_cfg.svh supplies the widths
// Notes:   All block state lives in one packed struct
`include "pci_wide_cfg.svh"

package pci_wide_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DECODE = 3'h1,
    ST_HIT    = 3'h3,
    ST_DATA   = 3'h2,
    ST_TURN   = 3'h6,
    ST_DONE   = 3'h7,
    ST_MISS   = 3'h5
  } tgt_state_e;

  typedef struct packed {
    tgt_state_e                    fsm;
    logic [`PCI_AD_W-1:0]          addr;
    logic [`PCI_CMD_W-1:0]         cmd;
    logic                          is_read;
    logic [`BAR_COUNT-1:0]         bar_hit;
    logic                          devsel_n;
    logic                          devsel_oe;
    logic                          trdy_n;
    logic                          trdy_oe;
    logic [`PCI_AD_W-1:0]          ad_out;
    logic                          ad_oe;
    logic                          lo_n;
    logic                          hi_n;
    logic [`LOCAL_DATA_W-1:0]      wdata;
    logic                          drive_half;
    logic                          rdy_seen;
    logic                          started;
    logic [1:0]                    ahead;
  } tgt_regs_s;

endpackage : pci_wide_pkg

// ### hw/pci_target_wide_local_adapter.sv
// Purpose: PCI target width adapter, 32-bit PCI bus to 64-bit local back-end
// Assumes: PCI pins are synchronous to core_clk_i (the PCI clock); memory commands only
// Notes:   Slow device-select timing; local strobes and ready are active low
`timescale 1ns/1ps
`include "pci_wide_cfg.svh"

// Overview of operation
// - Aligned read: low-half strobe one cycle after local ready seen.
// - Unaligned read: high-half strobe one cycle after local ready seen.
// - Read data DWORD sits on AD while target and initiator ready are both low.
// - Aligned read first phase: drop low strobe, raise high strobe if initiator and local ready.
// - Unaligned read: target ready after two ready cycles, upper DWORD driven.
// - Unaligned read: drop high strobe; low strobe if initiator and local ready.
// - Second read phase keeps target ready and drives the second DWORD.
// - At turnaround release AD, deassert device select and target ready.
// - Idle cycle: release device select and target ready, clear hits and strobes.
// - Clock after address phase: drive decoded address and command locally.
// - Address match drives BAR-hit outputs in the following clock.
// - Device select asserted one clock after BAR-hit.
// - Write: target ready the cycle after local ready.
// - Aligned write: first DWORD to low half, low strobe after completion.
// - Unaligned write: DWORD to high half, high strobe when all three ready.
// - QWORD-aligned start means low half first, otherwise high half first.
module pci_target_wide_local_adapter
  import pci_wide_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     frame_low_i,
  input  wire logic                     irdy_low_i,
  input  wire logic [`PCI_AD_W-1:0]     ad_i,
  input  wire logic [`PCI_CMD_W-1:0]    cbe_low_i,
  output logic      [`PCI_AD_W-1:0]     ad_o,
  output logic                          ad_oe_o,
  output logic                          devsel_low_o,
  output logic                          devsel_oe_o,
  output logic                          trdy_low_o,
  output logic                          trdy_oe_o,
  input  wire logic                     local_target_ready_low_i,
  input  wire logic [`LOCAL_DATA_W-1:0] local_read_data_i,
  output logic      [`LOCAL_DATA_W-1:0] local_write_data_bus_o,
  output logic      [`PCI_AD_W-1:0]     decoded_local_address_o,
  output logic      [`PCI_CMD_W-1:0]    decoded_local_command_o,
  output logic      [`BAR_COUNT-1:0]    bar_hit_o,
  output logic                          low_half_transfer_strobe_low_o,
  output logic                          high_half_transfer_strobe_low_o
);

  tgt_regs_s state_reg;
  tgt_regs_s state_next;

  function automatic logic bar_match(input logic [`PCI_AD_W-1:0] a,
                                     input logic [`PCI_AD_W-1:0] base);
    bar_match = ((a & `BAR_SIZE_MASK) == (base & `BAR_SIZE_MASK));
  endfunction : bar_match

  function automatic logic [`PCI_AD_W-1:0] pick_half(input logic [`LOCAL_DATA_W-1:0] q,
                                                     input logic hi);
    pick_half = hi ? q[`LOCAL_DATA_W-1:`HALF_HI_LSB] : q[`HALF_LO_MSB:0];
  endfunction : pick_half

  localparam logic [`PCI_AD_W-1:0] BAR_BASES [`BAR_COUNT] = '{`BAR0_BASE, `BAR1_BASE};

  logic                  rdy;
  logic                  irdy;
  logic                  frame;
  logic                  phase_done;
  logic                  last_done;
  logic                  next_half;
  logic [`BAR_COUNT-1:0] hits;

  // Polarity is flipped once here so the rest reads in positive sense
  assign rdy        = !local_target_ready_low_i;
  assign irdy       = !irdy_low_i;
  assign frame      = !frame_low_i;
  assign phase_done = (state_reg.fsm == ST_DATA) && irdy && !state_reg.trdy_n;
  assign last_done  = phase_done && !frame;
  assign next_half  = phase_done ? !state_reg.drive_half : state_reg.drive_half;

  genvar gi;
  generate
    for (gi = 0; gi < `BAR_COUNT; gi++) begin : g_bar
      assign hits[gi] = bar_match(state_reg.addr, BAR_BASES[gi]);
    end
  endgenerate

  always_comb begin
    state_next         = state_reg;
    // Strobes are single-cycle pulses unless re-raised below
    state_next.lo_n    = 1'b1;
    state_next.hi_n    = 1'b1;
    case (state_reg.fsm)
      ST_IDLE: begin
        if (frame) begin
          // Address and command latched here show up locally next clock
          state_next.addr       = ad_i;
          state_next.cmd        = cbe_low_i;
          state_next.is_read    = !cbe_low_i[`CMD_DIR_BIT];
          state_next.drive_half = ad_i[`QWORD_SEL_BIT];
          state_next.fsm        = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if ((hits != '0) &&
            ((state_reg.cmd == `CMD_MEM_READ) || (state_reg.cmd == `CMD_MEM_WRITE))) begin
          state_next.bar_hit = hits;
          state_next.fsm     = ST_HIT;
        end else begin
          state_next.fsm = ST_MISS;
        end
      end
      ST_HIT: begin
        state_next.devsel_n  = 1'b0;
        state_next.devsel_oe = 1'b1;
        state_next.trdy_n    = 1'b1;
        state_next.trdy_oe   = 1'b1;
        state_next.ad_oe     = state_reg.is_read;
        state_next.rdy_seen  = 1'b0;
        state_next.started   = 1'b0;
        state_next.ahead     = 2'h0;
        state_next.fsm       = ST_DATA;
      end
      ST_DATA: begin
        state_next.rdy_seen = rdy;
        if (state_reg.is_read) begin
          // AD follows the local bus every cycle, so it is valid when TRDY drops
          state_next.ad_out = pick_half(local_read_data_i, next_half);
          if (!state_reg.trdy_n) begin
            state_next.trdy_n = 1'b0;
          end else if (rdy && state_reg.rdy_seen) begin
            state_next.trdy_n = 1'b0;
          end
          if (rdy && !state_reg.started) begin
            state_next.started = 1'b1;
            state_next.ahead   = `AHEAD_ONE;
            state_next.lo_n    = state_reg.drive_half;
            state_next.hi_n    = !state_reg.drive_half;
          end else if (state_reg.started && irdy && rdy && frame &&
                       (state_reg.ahead < `AHEAD_LIMIT)) begin
            // Two QWORD halves fetched ahead at most; the other half is already held
            state_next.ahead = phase_done ? state_reg.ahead : state_reg.ahead + `AHEAD_ONE;
            state_next.lo_n  = !state_reg.drive_half ? 1'b1 : 1'b0;
            state_next.hi_n  = state_reg.drive_half ? 1'b1 : 1'b0;
          end else if (phase_done && (state_reg.ahead != 2'h0)) begin
            state_next.ahead = state_reg.ahead - `AHEAD_ONE;
          end
        end else begin
          if (!state_reg.trdy_n || rdy) begin
            state_next.trdy_n = 1'b0;
          end
          if (phase_done) begin
            if (state_reg.drive_half) begin
              state_next.wdata[`LOCAL_DATA_W-1:`HALF_HI_LSB] = ad_i;
              state_next.hi_n = !rdy;
            end else begin
              state_next.wdata[`HALF_LO_MSB:0] = ad_i;
              state_next.lo_n = 1'b0;
            end
          end
        end
        if (phase_done) begin
          state_next.drive_half = !state_reg.drive_half;
        end
        if (last_done) begin
          // Drive high for one cycle before release, as PCI wants
          state_next.ad_oe    = 1'b0;
          state_next.devsel_n = 1'b1;
          state_next.trdy_n   = 1'b1;
          state_next.fsm      = ST_TURN;
        end
      end
      ST_TURN: begin
        state_next.devsel_oe = 1'b0;
        state_next.trdy_oe   = 1'b0;
        state_next.bar_hit   = '0;
        state_next.fsm       = ST_DONE;
      end
      ST_DONE: begin
        state_next.fsm = ST_IDLE;
      end
      ST_MISS: begin
        // Not ours: wait until the bus goes idle before watching again
        if (!frame && !irdy) begin
          state_next.fsm = ST_IDLE;
        end
      end
      default: begin
        state_next.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg            <= '0;
      state_reg.fsm        <= ST_IDLE;
      state_reg.devsel_n   <= 1'b1;
      state_reg.trdy_n     <= 1'b1;
      state_reg.lo_n       <= 1'b1;
      state_reg.hi_n       <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ad_o                            = state_reg.ad_out;
  assign ad_oe_o                         = state_reg.ad_oe;
  assign devsel_low_o                    = state_reg.devsel_n;
  assign devsel_oe_o                     = state_reg.devsel_oe;
  assign trdy_low_o                      = state_reg.trdy_n;
  assign trdy_oe_o                       = state_reg.trdy_oe;
  assign local_write_data_bus_o          = state_reg.wdata;
  assign decoded_local_address_o         = state_reg.addr;
  assign decoded_local_command_o         = state_reg.cmd;
  assign bar_hit_o                       = state_reg.bar_hit;
  assign low_half_transfer_strobe_low_o  = state_reg.lo_n;
  assign high_half_transfer_strobe_low_o = state_reg.hi_n;

endmodule : pci_target_wide_local_adapter

// ### bench/pci_wide_chk.sv
// Purpose: Port-level checker for the PCI target width adapter
// Assumes: One clock domain, reset asynchronous and active high
// Notes:   Ties registered outputs other than ad_o, trdy_oe_o, the write bus and the decoded command to the pin values that cause them
`timescale 1ns/1ps
`include "pci_wide_cfg.svh"
module pci_wide_chk (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  frame_low_i,
  input  wire logic                  irdy_low_i,
  input  wire logic [`PCI_AD_W-1:0]  ad_i,
  input  wire logic                  local_target_ready_low_i,
  input  wire logic                  ad_oe_o,
  input  wire logic                  devsel_low_o,
  input  wire logic                  devsel_oe_o,
  input  wire logic                  trdy_low_o,
  input  wire logic [`PCI_AD_W-1:0]  decoded_local_address_o,
  input  wire logic [`PCI_CMD_W-1:0] decoded_local_command_o,
  input  wire logic [`BAR_COUNT-1:0] bar_hit_o,
  input  wire logic                  low_half_transfer_strobe_low_o,
  input  wire logic                  high_half_transfer_strobe_low_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire rd_c  = decoded_local_command_o == `CMD_MEM_READ;
  // A completion with frame already released is the last data phase
  wire lastc = !irdy_low_i && !trdy_low_o && frame_low_i;
  property p_dec; $fell(frame_low_i) && !devsel_oe_o |=> decoded_local_address_o == $past(ad_i);
  endproperty
  a_dec: assert property (p_dec) else $error("decoded address wrong");
  property p_hit; |bar_hit_o |->
    bar_hit_o[0] == ((decoded_local_address_o & `BAR_SIZE_MASK) == `BAR0_BASE); endproperty
  a_hit: assert property (p_hit) else $error("window hit wrong");
  property p_dev; $rose(|bar_hit_o) |=> !devsel_low_o && devsel_oe_o; endproperty
  a_dev: assert property (p_dev) else $error("device select late");
  property p_trdy; $fell(trdy_low_o) |-> $past(local_target_ready_low_i) == 1'b0; endproperty
  a_trdy: assert property (p_trdy) else $error("target ready without local ready");
  property p_rdlo; $fell(local_target_ready_low_i) && rd_c && !decoded_local_address_o[2]
    |=> !low_half_transfer_strobe_low_o; endproperty
  a_rdlo: assert property (p_rdlo) else $error("low strobe missing");
  property p_rdhi; $fell(local_target_ready_low_i) && rd_c && decoded_local_address_o[2]
    |=> !high_half_transfer_strobe_low_o; endproperty
  a_rdhi: assert property (p_rdhi) else $error("high strobe missing");
  property p_turn; lastc |=> trdy_low_o && devsel_low_o && !ad_oe_o; endproperty
  a_turn: assert property (p_turn) else $error("turnaround wrong");
  property p_idle; lastc |=> ##1 bar_hit_o == '0 && !devsel_oe_o
    && low_half_transfer_strobe_low_o && high_half_transfer_strobe_low_o; endproperty
  a_idle: assert property (p_idle) else $error("idle cycle wrong");
endmodule : pci_wide_chk

// ### bench/local_backend_model.sv
// Purpose: Behavioural local back-end behind the width adapter
// Assumes: Ready and strobes active low on the rising clock edge
// Notes:   Slow mode delays ready by one cycle after the window hit
`timescale 1ns/1ps
module local_backend_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic [1:0]  hit_i,
  input  wire logic        lo_low_i,
  input  wire logic        hi_low_i,
  input  wire logic [63:0] wbus_i,
  output logic             ready_low_o,
  output logic [63:0]      rdata_o,
  output logic [63:0]      wq_o
);
  logic [31:0] qa_reg;
  logic        seen_reg;
  logic [63:0] q;
  assign q = {32'h0000_0b00 + qa_reg, 32'h0000_0a00 + qa_reg};
  // Unselected data is inverted so a stale read cannot match
  assign rdata_o = (|hit_i) ? q : ~q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_low_o <= 1'b1;
      seen_reg <= 1'b0;
      qa_reg <= '0;
      wq_o <= '0;
    end else begin
      seen_reg <= |hit_i;
      ready_low_o <= ~(slow_i ? (seen_reg && |hit_i) : |hit_i);
      if (!hi_low_i && lo_low_i) begin
        qa_reg <= qa_reg + 32'h1;
        wq_o <= wbus_i;
      end
      // Low strobe alone neither writes nor advances
      if (!(|hit_i)) qa_reg <= '0;
    end
  end
endmodule : local_backend_model

// ### bench/pci_target_wide_local_adapter_tb.sv
// Purpose: Self-checking bench for the PCI target width adapter
// Assumes: Bench acts as PCI master, model acts as back-end
// Notes:   Every transfer that hits is two data phases, 64 bits; the miss has none
`timescale 1ns/1ps
`include "pci_wide_cfg.svh"
module pci_target_wide_local_adapter_tb;
  logic core_clk_i, sys_rst_i, frame_low_i, irdy_low_i, local_target_ready_low_i, slow, dsv;
  logic ad_oe_o, devsel_low_o, devsel_oe_o, trdy_low_o, trdy_oe_o;
  logic low_half_transfer_strobe_low_o, high_half_transfer_strobe_low_o;
  logic [31:0] ad_i, ad_o, decoded_local_address_o, mad, rd [2];
  logic [3:0]  cbe_low_i, decoded_local_command_o;
  logic [1:0]  bar_hit_o, hitv;
  logic [63:0] local_read_data_i, local_write_data_bus_o, wq;
  int          miscompares, checked, nd;
  assign ad_i = ad_oe_o ? ad_o : mad;
  pci_target_wide_local_adapter uut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .frame_low_i(frame_low_i),
    .irdy_low_i(irdy_low_i), .ad_i(ad_i), .cbe_low_i(cbe_low_i),
    .ad_o(ad_o), .ad_oe_o(ad_oe_o),
    .devsel_low_o(devsel_low_o), .devsel_oe_o(devsel_oe_o), .trdy_low_o(trdy_low_o),
    .trdy_oe_o(trdy_oe_o), .local_target_ready_low_i(local_target_ready_low_i),
    .local_read_data_i(local_read_data_i), .local_write_data_bus_o(local_write_data_bus_o),
    .decoded_local_address_o(decoded_local_address_o),
    .decoded_local_command_o(decoded_local_command_o), .bar_hit_o(bar_hit_o),
    .low_half_transfer_strobe_low_o(low_half_transfer_strobe_low_o),
    .high_half_transfer_strobe_low_o(high_half_transfer_strobe_low_o));
  local_backend_model be (.clk_i(core_clk_i), .rst_i(sys_rst_i), .slow_i(slow),
    .hit_i(bar_hit_o), .lo_low_i(low_half_transfer_strobe_low_o),
    .hi_low_i(high_half_transfer_strobe_low_o), .wbus_i(local_write_data_bus_o),
    .ready_low_o(local_target_ready_low_i), .rdata_o(local_read_data_i), .wq_o(wq));
  task automatic results;
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [31:0] a, input logic [3:0] c, input logic [31:0] w0, w1);
    nd = 0;
    dsv = 1'b0;
    hitv = '0;
    frame_low_i <= 1'b0;
    mad <= a;
    cbe_low_i <= c;
    @(posedge core_clk_i);
    irdy_low_i <= 1'b0;
    cbe_low_i <= 4'h0;
    mad <= w0;
    // Bounded so a miss ends as a master abort instead of a hang
    for (int k = 0; k < 14 && nd < 2; k++) begin
      @(posedge core_clk_i);
      hitv |= bar_hit_o;
      dsv |= devsel_oe_o;
      if (irdy_low_i === 1'b0 && trdy_low_o === 1'b0) begin
        rd[nd] = ad_o;
        nd++;
        frame_low_i <= 1'b1;
        mad <= w1;
      end
    end
    if (nd == 0) frame_low_i <= 1'b1;
    irdy_low_i <= 1'b1;
    cbe_low_i <= 4'hf;
    repeat (3) @(posedge core_clk_i);
  endtask : xfer
  task automatic rd_aligned;
    xfer(32'h1000_0000, `CMD_MEM_READ, 32'hffff_ffff, 32'hffff_ffff);
    chk(64'(rd[0]), 64'h0a00);
    chk(64'(rd[1]), 64'h0b00);
    chk(64'(hitv), 64'h1);
    chk(64'(bar_hit_o), 64'h0);
    chk(64'(trdy_oe_o), 64'h0);
    chk(64'(devsel_low_o), 64'h1);
    chk(64'(decoded_local_command_o), 64'(`CMD_MEM_READ));
  endtask : rd_aligned
  task automatic rd_unaligned;
    xfer(32'h2000_0004, `CMD_MEM_READ, 32'h0, 32'h0);
    chk(64'(rd[0]), 64'h0b00);
    chk(64'(rd[1]), 64'h0a01);
    chk(64'(hitv), 64'h2);
  endtask : rd_unaligned
  task automatic wr_aligned_slow;
    slow <= 1'b1;
    xfer(32'h1000_0008, `CMD_MEM_WRITE, 32'h1111_0001, 32'h2222_0002);
    chk(wq, 64'h2222_0002_1111_0001);
    chk(64'(nd), 64'h2);
    slow <= 1'b0;
  endtask : wr_aligned_slow
  task automatic wr_unaligned;
    xfer(32'h2000_000c, `CMD_MEM_WRITE, 32'h3333_0003, 32'h4444_0004);
    chk(64'(wq[63:32]), 64'h3333_0003);
    chk(64'(local_write_data_bus_o[31:0]), 64'h4444_0004);
    chk(64'(decoded_local_address_o), 64'h2000_000c);
    chk(64'(decoded_local_command_o), 64'(`CMD_MEM_WRITE));
  endtask : wr_unaligned
  task automatic miss;
    xfer(32'h3000_0000, `CMD_MEM_READ, 32'h0, 32'h0);
    chk(64'(nd), 64'h0);
    chk(64'(dsv), 64'h0);
  endtask : miss
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    // Six transfers need well under 200 cycles
    #50000;
    miscompares++;
    results();
  end
  initial begin
    sys_rst_i = 1'b1;
    frame_low_i = 1'b1;
    irdy_low_i = 1'b1;
    cbe_low_i = 4'hf;
    mad = '0;
    slow = 1'b0;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd_aligned();
    rd_unaligned();
    wr_aligned_slow();
    wr_unaligned();
    miss();
    rd_aligned();
    results();
  end
endmodule : pci_target_wide_local_adapter_tb
bind pci_target_wide_local_adapter pci_wide_chk chk_i (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .frame_low_i(frame_low_i),
  .irdy_low_i(irdy_low_i), .ad_i(ad_i),
  .local_target_ready_low_i(local_target_ready_low_i), .ad_oe_o(ad_oe_o),
  .devsel_low_o(devsel_low_o), .devsel_oe_o(devsel_oe_o), .trdy_low_o(trdy_low_o),
  .decoded_local_address_o(decoded_local_address_o),
  .decoded_local_command_o(decoded_local_command_o), .bar_hit_o(bar_hit_o),
  .low_half_transfer_strobe_low_o(low_half_transfer_strobe_low_o),
  .high_half_transfer_strobe_low_o(high_half_transfer_strobe_low_o));
